/* dv/sfr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  input wire logic ref_clk_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output var sfr_pkg::sfr_rd_req_t rd_req_o
);
  import sfr_pkg::*;
  // idle request, no read pending
  initial begin
    rd_req_o = '{en: 1'b0, addr: 8'h00};
  end
  // one byte per request; answer is looked at in its only valid cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge ref_clk_i);
    rd_req_o = '{en: 1'b1, addr: a};
    @(negedge ref_clk_i);
    // scrambled address after release so a stale decode cannot pass
    rd_req_o = '{en: 1'b0, addr: ~a};
    ok = (rd_valid_i === 1'b1);
    d = rd_data_i;
  endtask : rd
  // fifo data is always fetched at the pressure high address
  task automatic rd_fifo(output logic [7:0] d, output logic ok);
    rd(ADDR_P_HIGH, d, ok);
  endtask : rd_fifo
endmodule : sfr_host_model
`default_nettype wire

/* dv/sfr_sample_fifo_readout_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) check(n, e, a)
module sfr_sample_fifo_readout_tb;
  import sfr_pkg::*;
  localparam logic [7:0] PID = 8'h3C; // arbitrary value
  logic ref_clk_i, resetn_i, sample_valid_i, rd_valid, int_src, ok;
  sfr_fill_t fill_policy_i;
  logic [5:0] level_threshold_i;
  sfr_sample_t sample_i;
  sfr_rd_req_t rd_req;
  logic [7:0] rd_data, d;
  logic [15:0] rows [11];
  int bad_count, checks, i, k;
  sfr_sample_fifo_readout #(.PART_ID(PID)) i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .fill_policy_i(fill_policy_i), .level_threshold_i(level_threshold_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .rd_req_i(rd_req),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .fifo_int_src_o(int_src));
  sfr_host_model i_host (.ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .rd_req_o(rd_req));
  // free running 100 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // distinct samples, temperature steps by 3 lsb each
  function automatic sfr_sample_t mk(input int n);
    mk.pressure = 20'h1A2B3 + 20'(n) * 20'h00111;
    mk.temp = 12'h100 + 12'(n) * 12'h003;
  endfunction : mk
  // k-th byte of a sample on the fifo port
  function automatic logic [7:0] bt(input sfr_sample_t s, input int k);
    case (k)
      0: bt = s.pressure[19:12];
      1: bt = s.pressure[11:4];
      2: bt = {s.pressure[3:0], 4'h0};
      3: bt = s.temp[11:4];
      default: bt = {s.temp[3:0], 4'h0};
    endcase
  endfunction : bt
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] a);
    checks++;
    if (a !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, a);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : idle
  // read and confirm the one-cycle answer came
  task automatic rd(input logic [7:0] a);
    i_host.rd(a, d, ok);
    `CHK("rd_valid", 8'h01, {7'h00, ok});
  endtask : rd
  // status read after flags have had time to settle
  task automatic st(input logic [7:0] e);
    idle(2);
    rd(ADDR_FIFO_STATE);
    `CHK("status", e, d);
  endtask : st
  task automatic push(input int n);
    @(negedge ref_clk_i);
    sample_i = mk(n);
    sample_valid_i = 1'b1;
    @(negedge ref_clk_i);
    sample_valid_i = 1'b0;
  endtask : push
  // drain one whole sample at the pressure high address and compare its bytes
  task automatic pop(input int n);
    for (k = 0; k < 5; k++) begin
      i_host.rd_fifo(d, ok);
      `CHK("fifo byte", bt(mk(n), k), d);
    end
  endtask : pop
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // watchdog against a hung run
  initial begin
    #1ms;
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    resetn_i = 1'b0;
    fill_policy_i = FILL_OFF;
    level_threshold_i = 6'h00;
    sample_valid_i = 1'b0;
    sample_i = mk(0);
    idle(16);
    `CHK("reset data", 8'h00, rd_data);
    `CHK("reset valid", 8'h00, {7'h00, rd_valid});
    `CHK("reset int", 8'h00, {7'h00, int_src});
    resetn_i = 1'b1;
    st(8'h00);
    push(1);
    push(2);
    rows = '{{ADDR_P_HIGH, bt(mk(2), 0)}, {ADDR_P_MID, bt(mk(2), 1)}, {ADDR_P_LOW, bt(mk(2), 2)},
      {ADDR_T_HIGH, bt(mk(2), 3)}, {ADDR_T_LOW, bt(mk(2), 4)}, {ADDR_TCHG_HIGH, 8'h00},
      {ADDR_TCHG_LOW, 8'h30}, {ADDR_PART_ID, PID}, {ADDR_FIFO_STATE, 8'h00},
      {ADDR_FIFO_PORT, 8'h00}, {8'h3F, 8'h00}};
    for (i = 0; i < 11; i++) begin
      rd(rows[i][15:8]);
      `CHK("register", rows[i][7:0], d);
    end
    fill_policy_i = FILL_WRAP;
    level_threshold_i = 6'h01;
    push(3);
    push(4);
    rd(ADDR_TCHG_LOW);
    `CHK("tchg low", 8'h30, d);
    idle(2);
    `CHK("int set", 8'h01, {7'h00, int_src});
    st(8'h42);
    `CHK("int clear", 8'h00, {7'h00, int_src});
    st(8'h42);
    for (i = 2; i < 6; i++) begin
      rd(8'(i));
      `CHK("live zero", 8'h00, d);
    end
    // a new sample lands while the host is mid-sample
    for (k = 0; k < 5; k++) begin
      if (k == 2) push(5);
      i_host.rd_fifo(d, ok);
      `CHK("fifo byte", bt(mk(3), k), d);
    end
    st(8'h42);
    for (k = 0; k < 5; k++) begin
      rd(ADDR_FIFO_PORT);
      `CHK("port byte", bt(mk(4), k), d);
    end
    st(8'h01);
    pop(5);
    st(8'h00);
    i_host.rd_fifo(d, ok);
    `CHK("empty port", 8'h00, d);
    fill_policy_i = FILL_OFF;
    idle(2);
    fill_policy_i = FILL_STOP;
    level_threshold_i = 6'h00;
    for (i = 6; i < 39; i++) push(i);
    st(8'hA0);
    st(8'hA0);
    pop(6);
    st(8'h1F);
    fill_policy_i = FILL_OFF;
    st(8'h00);
    rd(ADDR_FIFO_PORT);
    `CHK("off port", 8'h00, d);
    fill_policy_i = FILL_WRAP;
    for (i = 40; i < 73; i++) push(i);
    st(8'hA0);
    pop(41);
    fill_policy_i = FILL_UNUSED;
    st(8'h00);
    resetn_i = 1'b0;
    idle(2);
    `CHK("reset data", 8'h00, rd_data);
    resetn_i = 1'b1;
    rd(ADDR_PART_ID);
    `CHK("part id", PID, d);
    rd(ADDR_TCHG_HIGH);
    `CHK("tchg reset", 8'h00, d);
    // falling temperature gives a negative two's complement change
    push(9);
    push(1);
    rd(ADDR_TCHG_HIGH);
    `CHK("tchg neg high", 8'hFE, d);
    rd(ADDR_TCHG_LOW);
    `CHK("tchg neg low", 8'h80, d);
    give_verdict();
  end
endmodule : sfr_sample_fifo_readout_tb
`default_nettype wire

/* verilog/sfr_pkg.sv */
`default_nettype none
package sfr_pkg;
  // register addresses on the byte-wide read port
  localparam logic [7:0] ADDR_P_HIGH = 8'h01;
  localparam logic [7:0] ADDR_P_MID = 8'h02;
  localparam logic [7:0] ADDR_P_LOW = 8'h03;
  localparam logic [7:0] ADDR_T_HIGH = 8'h04;
  localparam logic [7:0] ADDR_T_LOW = 8'h05;
  localparam logic [7:0] ADDR_TCHG_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_TCHG_LOW = 8'h0B;
  localparam logic [7:0] ADDR_PART_ID = 8'h0C;
  localparam logic [7:0] ADDR_FIFO_STATE = 8'h0D;
  localparam logic [7:0] ADDR_FIFO_PORT = 8'h0E;
  // fifo geometry and field layout
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_EMPTY = 6'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [2:0] BIDX_FIRST = 3'h0;
  localparam logic [2:0] BIDX_LAST = 3'h4;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] TCHG_RST = 12'h000;
  localparam logic [3:0] FRAC_PAD = 4'h0;
  // fill policy field encodings
  typedef enum logic [1:0] {
    FILL_OFF = 2'b00,
    FILL_WRAP = 2'b01,
    FILL_STOP = 2'b10,
    FILL_UNUSED = 2'b11
  } sfr_fill_t;
  // one acquired sample: q18.2 pressure, q8.4 temperature
  typedef struct packed {
    logic [19:0] pressure;
    logic [11:0] temp;
  } sfr_sample_t;
  // register read request from the serial front end
  typedef struct packed {
    logic en;
    logic [7:0] addr;
  } sfr_rd_req_t;
endpackage : sfr_pkg
`default_nettype wire

/* verilog/sfr_sample_fifo_readout.sv */
// Contract
// - temp change holds latest minus previous temperature
// - change is 12-bit signed, fraction in bits 7:4
// - temp change updates in every fill policy
// - part identifier is fixed, read-only, not reset
// - overflow flag set on overflow event
// - level flag set while count exceeds a nonzero threshold
// - status read clears fifo interrupt source bit
// - flags hold while condition lasts, reads don't clear
// - six-bit count, zero empty, up to 32
// - byte-wide read-only port, 32 samples max
// - five bytes per sample, pressure then temperature
// - enabled fifo readable at pressure high address
// - enabled fifo makes 02h to 05h read zero
// - sampling continues while host reads the fifo
// - fill policy: off, overwrite, stop, unused
// - draining a sample drops count by one
// - disabling flushes fifo, flags and count
`timescale 1ns/1ps
`default_nettype none
module sfr_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(D+1)-1:0] count_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [CW-1:0] cnt_q;
  logic push, pop;

  // a full buffer still takes a word when the drain pops in the same cycle
  assign in_ready_o = (cnt_q != CW'(D)) | out_ready_i;
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i & in_ready_o & ~flush_i;
  assign pop = out_valid_o & out_ready_i & ~flush_i;
  assign out_data_o = mem[rd_q];
  assign count_o = cnt_q;

  // storage, no reset needed since count gates every read
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : sfr_fifo

module sfr_sample_fifo_readout #(
  parameter logic [7:0] PART_ID = 8'h5A // arbitrary value, factory set
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire sfr_pkg::sfr_fill_t fill_policy_i,
  input wire logic [5:0] level_threshold_i,
  input wire logic sample_valid_i,
  input wire sfr_pkg::sfr_sample_t sample_i,
  input wire sfr_pkg::sfr_rd_req_t rd_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic fifo_int_src_o
);
  import sfr_pkg::*;

  sfr_sample_t head, live_q;
  logic [CNT_W-1:0] cnt;
  logic [2:0] bidx_q;
  logic [11:0] last_temp_q, tchg_q;
  logic have_q, ovf_q, mark_q, ovf_prev_q, mark_prev_q;
  logic fifo_on, full, head_valid, in_valid, in_ready;
  logic rd_fifo, take, drain_pop, wrap_pop, ovf_event, above, stat_rd, src_set;
  logic [7:0] rd_mux;

  // pick one byte of a sample in readout order
  function automatic logic [7:0] sample_byte(input sfr_sample_t s, input logic [2:0] idx);
    unique case (idx)
      3'h0: sample_byte = s.pressure[19:12];
      3'h1: sample_byte = s.pressure[11:4];
      3'h2: sample_byte = {s.pressure[3:0], FRAC_PAD};
      3'h3: sample_byte = s.temp[11:4];
      default: sample_byte = {s.temp[3:0], FRAC_PAD};
    endcase
  endfunction : sample_byte

  // policy decode; the unused code behaves as disabled
  assign fifo_on = (fill_policy_i == FILL_WRAP) || (fill_policy_i == FILL_STOP);
  assign full = (cnt == CNT_FULL);
  assign rd_fifo = rd_req_i.en && fifo_on &&
                   (rd_req_i.addr == ADDR_P_HIGH || rd_req_i.addr == ADDR_FIFO_PORT);
  assign take = rd_fifo & head_valid;
  assign drain_pop = take && (bidx_q == BIDX_LAST);
  // overwrite drops the oldest sample to make room for the new one
  assign wrap_pop = fifo_on && (fill_policy_i == FILL_WRAP) && sample_valid_i &&
                    full && !drain_pop;
  assign in_valid = sample_valid_i & fifo_on;
  // stop mode: in_ready low when full unless a drain pops that cycle, so the new sample is refused
  assign ovf_event = in_valid && (!in_ready || wrap_pop);
  assign above = fifo_on && (level_threshold_i != CNT_EMPTY) && (cnt > level_threshold_i);
  assign stat_rd = rd_req_i.en && (rd_req_i.addr == ADDR_FIFO_STATE);
  assign src_set = (ovf_q & ~ovf_prev_q) | (mark_q & ~mark_prev_q);

  sfr_fifo #(
    .W($bits(sfr_sample_t)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .flush_i(!fifo_on),
    .in_valid_i(in_valid),
    .in_data_i(sample_i),
    .in_ready_o(in_ready),
    .out_valid_o(head_valid),
    .out_data_o(head),
    .out_ready_i(drain_pop | wrap_pop),
    .count_o(cnt)
  );

  // byte position inside the oldest sample; restarts if that sample is overwritten
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bidx_q <= BIDX_FIRST;
    end else if (!fifo_on || wrap_pop || drain_pop) begin
      bidx_q <= BIDX_FIRST;
    end else if (take) begin
      bidx_q <= bidx_q + 3'h1;
    end
  end

  // temperature change, tracked regardless of fill policy
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_temp_q <= TCHG_RST;
      tchg_q <= TCHG_RST;
      have_q <= 1'b0;
      live_q <= '0;
    end else if (sample_valid_i) begin
      last_temp_q <= sample_i.temp;
      have_q <= 1'b1;
      live_q <= sample_i;
      // first sample has no predecessor, so change stays zero
      tchg_q <= have_q ? (sample_i.temp - last_temp_q) : TCHG_RST;
    end
  end

  // status flags follow their conditions, reading does not touch them
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovf_q <= 1'b0;
      mark_q <= 1'b0;
      ovf_prev_q <= 1'b0;
      mark_prev_q <= 1'b0;
    end else begin
      ovf_q <= fifo_on && (ovf_event || (ovf_q && full));
      mark_q <= above;
      ovf_prev_q <= ovf_q;
      mark_prev_q <= mark_q;
    end
  end

  // interrupt source bit: rising flag sets, status read clears, set wins
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_int_src_o <= 1'b0;
    end else if (src_set) begin
      fifo_int_src_o <= 1'b1;
    end else if (stat_rd) begin
      fifo_int_src_o <= 1'b0;
    end
  end

  // read data select
  always_comb begin
    rd_mux = BYTE_ZERO;
    unique case (rd_req_i.addr)
      ADDR_P_HIGH, ADDR_FIFO_PORT: begin
        if (fifo_on) begin
          rd_mux = head_valid ? sample_byte(head, bidx_q) : BYTE_ZERO;
        end else if (rd_req_i.addr == ADDR_P_HIGH) begin
          rd_mux = sample_byte(live_q, 3'h0);
        end
      end
      ADDR_P_MID, ADDR_P_LOW, ADDR_T_HIGH, ADDR_T_LOW: begin
        // live bytes vanish while the fifo owns the data window
        rd_mux = fifo_on ? BYTE_ZERO : sample_byte(live_q, 3'(rd_req_i.addr - ADDR_P_HIGH));
      end
      ADDR_TCHG_HIGH: rd_mux = tchg_q[11:4];
      ADDR_TCHG_LOW: rd_mux = {tchg_q[3:0], FRAC_PAD};
      ADDR_PART_ID: rd_mux = PART_ID;
      ADDR_FIFO_STATE: rd_mux = {ovf_q, mark_q, cnt};
      default: rd_mux = BYTE_ZERO;
    endcase
  end

  // registered answer one cycle after the request
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= BYTE_ZERO;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_req_i.en;
      if (rd_req_i.en) begin
        rd_data_o <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_new_temp;
    sample_valid_i && have_q;
  endsequence
  sequence s_above;
    above [*2];
  endsequence

  AST_TCHG_DIFF: assert property (s_new_temp |=>
    tchg_q == 12'($past(sample_i.temp) - $past(last_temp_q))) else $error("temp change wrong");
  AST_TCHG_OFF: assert property (s_new_temp and !fifo_on |=>
    tchg_q == 12'($past(sample_i.temp) - $past(last_temp_q))) else $error("change stuck off");
  AST_PART_ID: assert property (rd_req_i.en && rd_req_i.addr == ADDR_PART_ID |=>
    rd_valid_o && rd_data_o == PART_ID) else $error("part id wrong");
  AST_OVF_SET: assert property (ovf_event |=> ovf_q) else $error("overflow missed");
  AST_MARK_SET: assert property (s_above |-> mark_q) else $error("level mark missed");
  AST_INT_CLR: assert property (stat_rd && !src_set |=> !fifo_int_src_o)
    else $error("source not cleared");
  AST_OVF_HOLD: assert property (ovf_q && full && fifo_on |=> ovf_q)
    else $error("overflow dropped");
  AST_CNT_MAX: assert property (cnt <= CNT_FULL) else $error("count above 32");
  AST_DATA_ZERO: assert property (rd_req_i.en && fifo_on && rd_req_i.addr >= ADDR_P_MID &&
    rd_req_i.addr <= ADDR_T_LOW |=> rd_data_o == BYTE_ZERO) else $error("live byte leaked");
  AST_FILL_ON: assert property (in_valid && !full && !drain_pop |=>
    cnt == $past(cnt) + 6'h01) else $error("sample not stored");
  AST_EMPTY_ZERO: assert property (rd_fifo && cnt == CNT_EMPTY |=>
    rd_data_o == BYTE_ZERO) else $error("empty read not zero");
  AST_POP: assert property (drain_pop && !in_valid |=> cnt == $past(cnt) - 6'h01)
    else $error("count not decremented");
  AST_FLUSH: assert property (!fifo_on |=> cnt == CNT_EMPTY && !ovf_q && !mark_q)
    else $error("flush incomplete");
  AST_INT_SET: assert property (src_set |=> fifo_int_src_o)
    else $error("source not set");
  AST_RD_ANSWER: assert property (rd_req_i.en |=> rd_valid_o)
    else $error("read unanswered");
  AST_STAT_CNT: assert property (stat_rd |=> rd_data_o[5:0] == $past(cnt))
    else $error("count field wrong");
  AST_TCHG_FRAC: assert property (rd_req_i.en && rd_req_i.addr == ADDR_TCHG_LOW |=>
    rd_data_o[3:0] == 4'h0) else $error("change low nibble not zero");
  AST_STOP_HOLD: assert property (fill_policy_i == FILL_STOP && full && sample_valid_i &&
    !drain_pop |=> cnt == CNT_FULL) else $error("stop mode took a sample");

  // a stored sample leaves in five reads; byte position walks 0 to 4
  sequence s_first_byte;
    take && (bidx_q == BIDX_FIRST);
  endsequence
  sequence s_last_byte;
    take && (bidx_q == BIDX_LAST);
  endsequence
  sequence s_mid_byte;
    take && !drain_pop && !wrap_pop;
  endsequence

  AST_FIRST_BYTE: assert property (s_first_byte |=>
    rd_data_o == $past(head.pressure[19:12])) else $error("first fifo byte wrong");
  AST_LAST_BYTE: assert property (s_last_byte |=>
    rd_data_o == {$past(head.temp[3:0]), FRAC_PAD}) else $error("last fifo byte wrong");
  AST_BYTE_STEP: assert property (s_mid_byte |=> bidx_q == $past(bidx_q) + 3'h1)
    else $error("byte position stuck");
endmodule : sfr_sample_fifo_readout
`default_nettype wire
